/* core/repository_change_event_consts.svh */
// register offsets, field positions and reset values of the change event framer
`ifndef REPOSITORY_CHANGE_EVENT_CONSTS_SVH
`define REPOSITORY_CHANGE_EVENT_CONSTS_SVH
`define CTRL_OFS      8'h00
`define REC_OFS       8'h04
`define ENTRY_OFS     8'h08
`define STATUS_OFS    8'h0C
`define ERR_OFS       8'h10
`define START_BIT     0
`define RESTART_BIT   1
`define FMT_LSB       8
`define CNT_LSB       16
`define OP_LSB        0
`define ECNT_LSB      8
`define ST_BUSY_BIT   0
`define ST_STATE_LSB  1
`define ST_PHASE_LSB  4
`define ST_BYTES_LSB  16
`define ERR_FMT       0
`define ERR_WHOLE_CNT 1
`define ERR_OP        2
`define ERR_ORDER     3
`define ERR_RALL      4
`define ERR_SEQ       5
`define ERR_MTU       6
`define ERR_W         7
`define ERR_RST       7'h00
`define COUNT_RST     8'h00
`define BYTES_RST     16'h0000
`define BASELINE_MTU  16'h0040
`define HDR_BYTES     3'h2
`define REC_BYTES     3'h2
`define ENT_BYTES     3'h4
`endif

/* core/repository_change_event_pkg.sv */
// types of the change event framer
package repository_change_event_pkg;
  typedef enum logic [7:0] {refresh_whole_repository, entries_are_types, entries_are_handles} entry_format_e;
  typedef enum logic [7:0] {op_refresh_all, op_deleted, op_added, op_modified} record_operation_e;
  typedef enum logic [1:0] {st_idle, st_record, st_entry} frame_state_e;
endpackage

/* core/two_entry_buffer.sv */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module two_entry_buffer #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign in_ready  = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_r[rp_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // two_entry_buffer

/* core/field_serializer.sv */
// splits one field word into bytes, least significant first
`timescale 1ns/10ps
module field_serializer (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ld,
  input  wire logic [31:0] ld_word,
  input  wire logic [2:0]  ld_nb,
  input  wire logic        ld_last,
  output logic             busy,
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic [7:0]       out_data,
  output logic             out_last
);
  logic [31:0] shift_r;
  logic [2:0]  cnt_r;
  logic        last_r;

  assign busy      = cnt_r != 3'h0;
  assign out_valid = busy;
  assign out_data  = shift_r[7:0];
  assign out_last  = last_r & (cnt_r == 3'h1);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shift_r <= 32'h0000_0000;
      cnt_r   <= 3'h0;
      last_r  <= 1'b0;
    end else if (ld && !busy) begin
      shift_r <= ld_word;
      cnt_r   <= ld_nb;
      last_r  <= ld_last;
    end else if (out_valid && out_ready) begin
      shift_r <= {8'h00, shift_r[31:8]};
      cnt_r   <= cnt_r - 3'h1;
    end
  end

  a_byte_order: assert property (@(posedge clk) disable iff (sys_rst)
    (out_valid && out_ready && cnt_r > 3'h1) |=> out_data == $past(shift_r[15:8]))
    else $error("next byte is not the next higher byte");
endmodule // field_serializer

/* core/repository_change_event_framer.sv */
// repository change event framer: wishbone registers in, payload bytes out
`timescale 1ns/10ps
`include "repository_change_event_consts.svh"
module repository_change_event_framer
  import repository_change_event_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [7:0]       tx_data,
  output logic             tx_last
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  frame_state_e        st_r;
  logic [7:0]          fmt_r;
  logic [7:0]          rec_left_r;
  logic [7:0]          ent_left_r;
  logic [7:0]          msg_op_r;
  logic [7:0]          phase_r;
  logic [15:0]         bytes_r;
  logic [15:0]         bytes_nxt;
  logic [`ERR_W-1:0]   err_r;
  logic [`ERR_W-1:0]   err_set;
  logic                ack_r;
  logic [31:0]         rdata_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic        req;
  logic        full_sel;
  logic        wr_ctrl;
  logic        wr_start;
  logic        wr_rec;
  logic        wr_ent;
  logic        emit_wr;
  logic        stall;
  logic [7:0]  fmt_in;
  logic [7:0]  cnt_in;
  logic [7:0]  op_in;
  logic [7:0]  ecnt_in;

  assign req      = wb_cyc_i & wb_stb_i & ~ack_r;
  assign full_sel = wb_sel_i == 4'hF;
  assign wr_ctrl  = req & wb_we_i & full_sel & (wb_adr_i == `CTRL_OFS);
  assign wr_start = wr_ctrl & wb_dat_i[`START_BIT];
  assign wr_rec   = req & wb_we_i & full_sel & (wb_adr_i == `REC_OFS);
  assign wr_ent   = req & wb_we_i & full_sel & (wb_adr_i == `ENTRY_OFS);
  assign emit_wr  = wr_start | wr_rec | wr_ent;
  assign fmt_in   = wb_dat_i[`FMT_LSB +: 8];
  assign cnt_in   = wb_dat_i[`CNT_LSB +: 8];
  assign op_in    = wb_dat_i[`OP_LSB +: 8];
  assign ecnt_in  = wb_dat_i[`ECNT_LSB +: 8];

  ////////////////////////////////////////////////////////////////////////////
  // acceptance checks
  logic ser_busy;
  logic fmt_bad;
  logic whole_cnt_bad;
  logic op_bad;
  logic order_bad;
  logic rall_bad;
  logic hdr_ok;
  logic rec_ok;
  logic hdr_go;
  logic rec_go;
  logic ent_go;
  logic seq_bad;
  logic mtu_over;

  assign stall         = emit_wr & ser_busy;
  assign fmt_bad       = fmt_in > 8'(entries_are_handles);
  assign whole_cnt_bad = (fmt_in == 8'(refresh_whole_repository)) && (cnt_in != `COUNT_RST);
  assign op_bad        = op_in > 8'(op_modified);
  assign rall_bad      = (op_in == 8'(op_refresh_all)) && (fmt_r != 8'(entries_are_types));
  // within the message operations never go back; across messages removals,
  // then additions, then modifications
  assign order_bad     = (op_in < msg_op_r)
                      || ((op_in != 8'(op_refresh_all)) && (op_in < phase_r));
  assign hdr_ok        = (st_r == st_idle) && !fmt_bad && !whole_cnt_bad;
  assign rec_ok        = (st_r == st_record) && !op_bad && !order_bad && !rall_bad;
  assign hdr_go        = wr_start & ~ser_busy & hdr_ok;
  assign rec_go        = wr_rec & ~ser_busy & rec_ok;
  assign ent_go        = wr_ent & ~ser_busy & (st_r == st_entry);
  assign seq_bad       = ~ser_busy & ((wr_start & (st_r != st_idle))
                      | (wr_rec & (st_r != st_record)) | (wr_ent & (st_r != st_entry)));

  always_comb begin
    bytes_nxt = bytes_r;
    if (hdr_go) begin
      bytes_nxt = 16'(`HDR_BYTES);
    end else if (rec_go) begin
      bytes_nxt = bytes_r + 16'(`REC_BYTES);
    end else if (ent_go) begin
      bytes_nxt = bytes_r + 16'(`ENT_BYTES);
    end
  end
  assign mtu_over = (hdr_go | rec_go | ent_go) && (bytes_nxt > `BASELINE_MTU);

  always_comb begin
    err_set                 = `ERR_RST;
    err_set[`ERR_FMT]       = wr_start & ~ser_busy & (st_r == st_idle) & fmt_bad;
    err_set[`ERR_WHOLE_CNT] = wr_start & ~ser_busy & (st_r == st_idle) & ~fmt_bad & whole_cnt_bad;
    err_set[`ERR_OP]        = wr_rec & ~ser_busy & (st_r == st_record) & op_bad;
    err_set[`ERR_ORDER]     = wr_rec & ~ser_busy & (st_r == st_record) & ~op_bad & order_bad;
    err_set[`ERR_RALL]      = wr_rec & ~ser_busy & (st_r == st_record) & ~op_bad & rall_bad;
    err_set[`ERR_SEQ]       = seq_bad;
    err_set[`ERR_MTU]       = mtu_over;
  end

  ////////////////////////////////////////////////////////////////////////////
  // serializer load
  logic        ld;
  logic [31:0] ld_word;
  logic [2:0]  ld_nb;
  logic        ld_last;

  assign ld = hdr_go | rec_go | ent_go;

  always_comb begin
    ld_word = 32'h0000_0000;
    ld_nb   = 3'h0;
    ld_last = 1'b0;
    if (hdr_go) begin
      ld_word = {16'h0000, cnt_in, fmt_in};
      ld_nb   = `HDR_BYTES;
      ld_last = cnt_in == `COUNT_RST;
    end else if (rec_go) begin
      ld_word = {16'h0000, ecnt_in, op_in};
      ld_nb   = `REC_BYTES;
      ld_last = (ecnt_in == `COUNT_RST) && (rec_left_r == 8'h01);
    end else if (ent_go) begin
      ld_word = wb_dat_i;
      ld_nb   = `ENT_BYTES;
      ld_last = (ent_left_r == 8'h01) && (rec_left_r == 8'h01);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencing
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r       <= st_idle;
      rec_left_r <= `COUNT_RST;
      ent_left_r <= `COUNT_RST;
    end else if (hdr_go) begin
      rec_left_r <= cnt_in;
      st_r       <= (cnt_in == `COUNT_RST) ? st_idle : st_record;
    end else if (rec_go) begin
      if (ecnt_in == `COUNT_RST) begin
        rec_left_r <= rec_left_r - 8'h01;
        st_r       <= (rec_left_r == 8'h01) ? st_idle : st_record;
      end else begin
        ent_left_r <= ecnt_in;
        st_r       <= st_entry;
      end
    end else if (ent_go) begin
      ent_left_r <= ent_left_r - 8'h01;
      if (ent_left_r == 8'h01) begin
        rec_left_r <= rec_left_r - 8'h01;
        st_r       <= (rec_left_r == 8'h01) ? st_idle : st_record;
      end
    end
  end

  // the selector is latched once per message and governs every entry of it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fmt_r <= 8'(refresh_whole_repository);
    end else if (hdr_go) begin
      fmt_r <= fmt_in;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      msg_op_r <= 8'(op_refresh_all);
    end else if (hdr_go) begin
      msg_op_r <= 8'(op_refresh_all);
    end else if (rec_go) begin
      msg_op_r <= op_in;
    end
  end

  // ordering phase carried across messages until software restarts it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_r <= `COUNT_RST;
    end else if (rec_go && op_in != 8'(op_refresh_all)) begin
      phase_r <= op_in;
    end else if (wr_ctrl && !ser_busy && wb_dat_i[`RESTART_BIT] && st_r == st_idle) begin
      phase_r <= `COUNT_RST;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bytes_r <= `BYTES_RST;
    end else begin
      bytes_r <= bytes_nxt;
    end
  end

  // sticky errors, a new event wins over a clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      err_r <= `ERR_RST;
    end else if (req && wb_we_i && full_sel && wb_adr_i == `ERR_OFS) begin
      err_r <= (err_r & ~wb_dat_i[`ERR_W-1:0]) | err_set;
    end else begin
      err_r <= err_r | err_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus answer
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (wb_adr_i)
      `CTRL_OFS: begin
        rdata_nxt[`FMT_LSB +: 8] = fmt_r;
        rdata_nxt[`CNT_LSB +: 8] = rec_left_r;
      end
      `REC_OFS: begin
        rdata_nxt[`OP_LSB +: 8]   = msg_op_r;
        rdata_nxt[`ECNT_LSB +: 8] = ent_left_r;
      end
      `STATUS_OFS: begin
        rdata_nxt[`ST_BUSY_BIT]        = ser_busy | (st_r != st_idle);
        rdata_nxt[`ST_STATE_LSB +: 2]  = st_r;
        rdata_nxt[`ST_PHASE_LSB +: 8]  = phase_r;
        rdata_nxt[`ST_BYTES_LSB +: 16] = bytes_r;
      end
      `ERR_OFS: begin
        rdata_nxt[`ERR_W-1:0] = err_r;
      end
      default: begin
        rdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_r    <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~stall;
      if (req && !stall && !wb_we_i) begin
        wb_dat_o <= rdata_nxt;
      end
    end
  end
  assign wb_ack_o = ack_r;

  ////////////////////////////////////////////////////////////////////////////
  // byte path
  logic       sv_valid;
  logic       sv_ready;
  logic [7:0] sv_data;
  logic       sv_last;

  field_serializer u_ser (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .ld        (ld),
    .ld_word   (ld_word),
    .ld_nb     (ld_nb),
    .ld_last   (ld_last),
    .busy      (ser_busy),
    .out_valid (sv_valid),
    .out_ready (sv_ready),
    .out_data  (sv_data),
    .out_last  (sv_last)
  );

  two_entry_buffer #(.WIDTH(9), .DEPTH(2)) u_buf (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (sv_valid),
    .in_ready  (sv_ready),
    .in_data   ({sv_last, sv_data}),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  ({tx_last, tx_data})
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_ack_single: assert property (@(posedge clk) disable iff (sys_rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_fmt_legal: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r != st_idle) |-> (fmt_r == 8'(entries_are_types) || fmt_r == 8'(entries_are_handles)))
    else $error("message open with illegal selector");

  a_fmt_stable: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r != st_idle && $past(st_r) != st_idle) |-> $stable(fmt_r))
    else $error("selector changed inside a message");

  a_whole_empty: assert property (@(posedge clk) disable iff (sys_rst)
    (hdr_go && fmt_in == 8'(refresh_whole_repository)) |-> ld_last ##1 st_r == st_idle)
    else $error("whole refresh carried change records");

  a_zero_count_end: assert property (@(posedge clk) disable iff (sys_rst)
    (hdr_go && cnt_in == `COUNT_RST) |=> (st_r == st_idle && ser_busy))
    else $error("zero count did not end the payload");

  a_op_monotone: assert property (@(posedge clk) disable iff (sys_rst)
    rec_go |-> (op_in >= msg_op_r && op_in <= 8'(op_modified)))
    else $error("record operation out of order");

  a_phase_order: assert property (@(posedge clk) disable iff (sys_rst)
    (rec_go && op_in != 8'(op_refresh_all)) |-> op_in >= phase_r)
    else $error("removal, addition or modification out of order");

  a_rall_types: assert property (@(posedge clk) disable iff (sys_rst)
    (rec_go && op_in == 8'(op_refresh_all)) |-> fmt_r == 8'(entries_are_types))
    else $error("refresh all without type selector");

  a_bad_op_flag: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_rec && !ser_busy && st_r == st_record && op_bad) |=> (err_r[`ERR_OP] && st_r == st_record))
    else $error("illegal operation not refused");

  a_entry_width: assert property (@(posedge clk) disable iff (sys_rst)
    ent_go |-> ld_nb == `ENT_BYTES ##1 ser_busy [*4])
    else $error("entry not four bytes");
endmodule // repository_change_event_framer

/* verif/event_receiver_model.sv */
// receiver side model: takes payload bytes with prompt or slow ready
`timescale 1ns/10ps
module event_receiver_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       slow,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready
);
  logic [1:0] cnt_r;
  logic [8:0] got[$];
  logic [2:0] ps_r;
  logic [7:0] sel_r;
  logic [7:0] rec_r;
  logic [7:0] ent_r;
  logic [1:0] bi_r;
  int         reenum_cnt = 0;
  int         fetch_cnt = 0;
  int         find_cnt = 0;
  ////////////////////////////////////////////////////////////////
  // ready every cycle, or one cycle in four when slow
  always @(posedge clk) begin
    cnt_r <= sys_rst ? 2'h0 : cnt_r + 2'h1;
    tx_ready <= !sys_rst && (!slow || cnt_r == 2'h3);
  end
  // keeps bytes in arrival order for the change list
  always @(posedge clk) begin
    if (!sys_rst && tx_valid && tx_ready) got.push_back({tx_last, tx_data});
  end
  // walks each message: handles fetched one by one, types looked up, whole refresh re-enumerates
  always @(posedge clk) begin
    if (sys_rst) begin
      ps_r <= 3'h0;
      bi_r <= 2'h0;
    end else if (tx_valid && tx_ready) begin
      case (ps_r)
        3'h0: begin
          sel_r <= tx_data;
          ps_r  <= 3'h1;
        end
        3'h1: begin
          rec_r <= tx_data;
          ps_r  <= (tx_data == 8'h00) ? 3'h0 : 3'h2;
          if (tx_data == 8'h00 && sel_r == 8'h00) begin
            reenum_cnt <= reenum_cnt + 1;
          end
        end
        3'h2: begin
          ps_r <= 3'h3;
        end
        3'h3: begin
          ent_r <= tx_data;
          bi_r  <= 2'h0;
          if (tx_data != 8'h00) begin
            ps_r <= 3'h4;
          end else begin
            rec_r <= rec_r - 8'h01;
            ps_r  <= (rec_r == 8'h01) ? 3'h0 : 3'h2;
          end
        end
        default: begin
          bi_r <= bi_r + 2'h1;
          if (bi_r == 2'h3) begin
            if (sel_r == 8'h02) begin
              fetch_cnt <= fetch_cnt + 1;
            end else begin
              find_cnt <= find_cnt + 1;
            end
            ent_r <= ent_r - 8'h01;
            if (ent_r == 8'h01) begin
              rec_r <= rec_r - 8'h01;
              ps_r  <= (rec_r == 8'h01) ? 3'h0 : 3'h2;
            end
          end
        end
      endcase
      if (tx_last) begin
        ps_r <= 3'h0;
      end
    end
  end
endmodule // event_receiver_model

/* verif/repository_change_event_framer_tb.sv */
// self-checking bench of the change event framer
`timescale 1ns/10ps
`include "repository_change_event_consts.svh"
module repository_change_event_framer_tb
  import repository_change_event_pkg::*;
;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hF;
  logic [31:0] dat = 32'h0000_0000;
  logic        slow = 1'b0;
  logic [31:0] dat_o;
  logic        ack;
  logic        tx_valid;
  logic        tx_ready;
  logic        tx_last;
  logic [7:0]  tx_data;
  int          failures = 0;
  int          num_checks = 0;
  logic [8:0]  exp_q[$];
  ////////////////////////////////////////////////////////////////
  repository_change_event_framer DUT (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .wb_cyc_i (cyc),
    .wb_stb_i (stb),
    .wb_we_i  (we),
    .wb_adr_i (adr),
    .wb_sel_i (sel),
    .wb_dat_i (dat),
    .wb_dat_o (dat_o),
    .wb_ack_o (ack),
    .tx_valid (tx_valid),
    .tx_ready (tx_ready),
    .tx_data  (tx_data),
    .tx_last  (tx_last)
  );
  event_receiver_model rx (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .slow     (slow),
    .tx_valid (tx_valid),
    .tx_data  (tx_data),
    .tx_last  (tx_last),
    .tx_ready (tx_ready)
  );
  initial forever #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'hF, q);
    chk(q, e);
  endtask
  task automatic err_is(input logic [31:0] e);
    rd(`ERR_OFS, e);
    wr(`ERR_OFS, 32'h0000_007F);
  endtask
  task automatic put(input logic [31:0] w, input int nb, input logic last);
    for (int i = 0; i < nb; i++) exp_q.push_back({last && i == nb - 1, w[8*i +: 8]});
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (rx.got.size() < exp_q.size() && n < 3000) begin
      @(posedge clk);
      n++;
    end
    repeat (20) @(posedge clk);
    chk(rx.got.size(), exp_q.size());
    foreach (exp_q[i]) if (i < rx.got.size()) chk({23'h0, rx.got[i]}, {23'h0, exp_q[i]});
    rx.got.delete();
    exp_q.delete();
  endtask
  function automatic logic [31:0] ctl(input logic [7:0] s, input logic [7:0] c);
    return {8'h00, c, s, 8'h01};
  endfunction
  function automatic logic [31:0] rec(input logic [7:0] o, input logic [7:0] c);
    return {16'h0000, c, o};
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    #400_000;
    failures++;
    finish_test();
  end
  initial begin
    logic [31:0] q;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`STATUS_OFS, 32'h0000_0000);
    rd(`CTRL_OFS, 32'h0000_0000);
    err_is(32'h0000_0000);
    // header, one record, one entry
    wr(`CTRL_OFS, ctl(entries_are_types, 8'h01));
    wr(`REC_OFS, rec(op_added, 8'h01));
    wr(`ENTRY_OFS, 32'hAABB_CCDD);
    put(32'h0000_0101, 2, 1'b0);
    put(32'h0000_0102, 2, 1'b0);
    put(32'hAABB_CCDD, 4, 1'b1);
    drain();
    err_is(32'h0000_0000);
    // whole refresh
    wr(`CTRL_OFS, ctl(refresh_whole_repository, 8'h02));
    err_is(32'h0000_0002);
    wr(`CTRL_OFS, ctl(refresh_whole_repository, 8'h00));
    put(32'h0000_0000, 2, 1'b1);
    drain();
    // refusals while idle
    wr(`CTRL_OFS, ctl(8'h03, 8'h01));
    err_is(32'h0000_0001);
    wr(`ENTRY_OFS, 32'h0000_0001);
    err_is(32'h0000_0020);
    bus(1'b1, `CTRL_OFS, ctl(entries_are_types, 8'h01), 4'h3, q);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0000_0000);
    err_is(32'h0000_0000);
    drain();
    // bad operations inside a handles message
    wr(`CTRL_OFS, 32'h0000_0002);
    wr(`CTRL_OFS, ctl(entries_are_handles, 8'h01));
    wr(`REC_OFS, rec(op_refresh_all, 8'h00));
    err_is(32'h0000_0010);
    wr(`REC_OFS, rec(8'h04, 8'h00));
    err_is(32'h0000_0004);
    wr(`REC_OFS, rec(op_deleted, 8'h00));
    put(32'h0000_0102, 2, 1'b0);
    put(32'h0000_0001, 2, 1'b1);
    drain();
    // every operation in order, then a late removal
    wr(`CTRL_OFS, ctl(entries_are_types, 8'h04));
    put(32'h0000_0401, 2, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(`REC_OFS, rec(i[7:0], 8'h00));
      put(32'(i), 2, i == 3);
    end
    drain();
    rd(`STATUS_OFS, 32'h000A_0030);
    rd(`REC_OFS, 32'h0000_0003);
    rd(`CTRL_OFS, 32'h0000_0100);
    wr(`CTRL_OFS, ctl(entries_are_handles, 8'h01));
    wr(`REC_OFS, rec(op_deleted, 8'h00));
    err_is(32'h0000_0008);
    wr(`REC_OFS, rec(op_modified, 8'h00));
    put(32'h0000_0102, 2, 1'b0);
    put(32'h0000_0003, 2, 1'b1);
    drain();
    // long message under a stalling receiver
    wr(`CTRL_OFS, 32'h0000_0002);
    slow <= 1'b1;
    wr(`CTRL_OFS, ctl(entries_are_handles, 8'h01));
    wr(`REC_OFS, rec(op_added, 8'h10));
    put(32'h0000_0102, 2, 1'b0);
    put(32'h0000_1002, 2, 1'b0);
    rd(`STATUS_OFS, 32'h0004_0025);
    for (int i = 0; i < 16; i++) begin
      wr(`ENTRY_OFS, 32'hC0DE_0000 + i);
      put(32'hC0DE_0000 + i, 4, i == 15);
    end
    drain();
    err_is(32'h0000_0040);
    chk(rx.reenum_cnt, 32'h0000_0001);
    chk(rx.fetch_cnt, 32'h0000_0010);
    chk(rx.find_cnt, 32'h0000_0001);
    slow <= 1'b0;
    finish_test();
  end
endmodule // repository_change_event_framer_tb
